// ==== src/cspl_pkg.sv ====
/*
  Constants for the configuration-space power and link register bank:
  register offsets, field positions, write masks and reset values.
  Assumes the config-cycle port hands over dword-aligned byte offsets.
*/
`default_nettype none
package cspl_pkg;
  // Register byte offsets in configuration space
  localparam logic [7:0] CSPL_OFS_LINK_PWR = 8'hec;
  localparam logic [7:0] CSPL_OFS_CFG_LOAD = 8'hf0;
  localparam logic [7:0] CSPL_OFS_IRQ_SEL = 8'hf4;
  localparam logic [7:0] CSPL_OFS_INT_STAT = 8'hf8;

  // Link power control fields
  localparam int CSPL_LP_RST_REL = 0;
  localparam int CSPL_LP_FSYNC = 1;
  localparam int CSPL_LP_WAKE1 = 2;
  localparam int CSPL_LP_WAKE2 = 3;
  localparam int CSPL_LP_SEC_EN = 8;
  localparam int CSPL_LP_EE_DIS = 9;
  localparam int CSPL_LP_SEC_EV = 14;
  localparam int CSPL_LP_PRI_EV = 15;
  localparam logic [31:0] CSPL_LP_WR_MASK = 32'h0000_c303;
  localparam logic [31:0] CSPL_LP_RESET = 32'h0000_0000;

  // Legacy interrupt select fields
  localparam int CSPL_IS_MAP_W = 4;
  localparam int CSPL_IS_MAP_A = 0;
  localparam int CSPL_IS_MAP_B = 8;
  localparam int CSPL_IS_MAP_C = 16;
  localparam int CSPL_IS_GTD = 23;
  localparam int CSPL_IS_FWF = 24;
  localparam int CSPL_IS_AUX_POWER_FLAG = 27;
  localparam int CSPL_IS_VAC = 28;
  localparam int CSPL_IS_AUX_SUPPLY_SUPPORT = 31;
  localparam logic [31:0] CSPL_IS_WR_MASK = 32'hff8f_0f0f;
  localparam logic [31:0] CSPL_IS_RESET = 32'h0000_0000;

  localparam logic [31:0] CSPL_CL_RESET = 32'h0000_0000;

  // Interrupt aggregation
  localparam int CSPL_INT_SRC_W = 8;
  localparam logic [CSPL_INT_SRC_W-1:0] CSPL_INT_RESET = 8'h00;
  localparam int CSPL_LEG_PINS = 3;
endpackage
`default_nettype wire

// ==== src/cspl_rise_det.sv ====
/*
  Rising-edge detector for W synchronous levels.
  Assumes the input is already synchronous to clk.
*/
`default_nettype none
module cspl_rise_det #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in, pulse out
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise
);
  logic [W-1:0] prev_ff;
  logic [W-1:0] nxt_prev;

  always_comb begin
    nxt_prev = din;
    rise = din & ~prev_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end
endmodule
`default_nettype wire

// ==== src/cspl_regs.sv ====
/*
  Configuration-space register bank for codec link power management,
  EEPROM-loaded option bytes, legacy interrupt mapping and host interrupt
  aggregation. Assumes a decoded config-cycle port (one-cycle strobes),
  pci_rst_n synchronous to clk, and rst_n as the power-on reset.
*/
// Behaviour
// - Codec reset low if bit clear or PCI reset
// - Forced sync bit drives sync high immediately
// - Primary input rising while link down sets wake
// - Secondary input rising while link down and enabled sets wake
// - Wake flags clear on forced sync falling edge
// - Primary slot-12 rise raises event when enabled
// - Secondary slot-12 rise raises event when enabled
// - Loader disabled: no read, pins detached
// - Loader enabled: read EEPROM after power-on
// - Secondary pin: GP pin or codec input
// - Two registers survive PCI bus reset
// - Writes, except status clear, only when write protect permits
// - Option bytes loaded from EEPROM or firmware
// - First option byte in lowest byte lane
// - Aux support mirrored to cold-D3 support
// - Aux current code mirrored to capability
// - Aux power bit mirrored to capability
// - Firmware flags are plain storage
// - Global trap disable suppresses all trapping
// - Zero map keeps legacy pin undriven
// - Legacy pin enable: map and software enable
// - Merge sources onto one host interrupt line
`default_nettype none
module cspl_regs
  import cspl_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pci_rst_n,
  // Configuration cycle port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic config_write_protect,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Codec link
  input wire logic link_down,
  input wire logic normal_sync,
  input wire logic primary_serial_in,
  input wire logic secondary_serial_in,
  input wire logic primary_gp_int,
  input wire logic secondary_gp_int,
  output logic codec_reset_out_n,
  output logic link_sync_pin,
  output logic secondary_codec_data,
  output logic extended_gp_pin,
  output logic secondary_input_enable,
  output logic pme_event,
  // EEPROM loader
  input wire logic ee_byte_valid,
  input wire logic [1:0] ee_byte_idx,
  input wire logic [7:0] ee_byte_data,
  output logic eeprom_load_start,
  output logic eeprom_pins_attach,
  // Power capability mirrors and flags
  output logic cold_d3_support,
  output logic [2:0] aux_current_code,
  output logic aux_power_flag,
  output logic [2:0] firmware_flags,
  // Legacy trapping
  input wire logic io_trap_hit,
  output logic io_trap_fire,
  // Legacy interrupt pins
  input wire logic [CSPL_LEG_PINS-1:0] legacy_irq_sw_en,
  input wire logic [CSPL_LEG_PINS-1:0] legacy_irq_req,
  output logic [CSPL_LEG_PINS-1:0] legacy_irq_o,
  output logic [CSPL_LEG_PINS-1:0] legacy_irq_oe,
  // Host interrupt
  input wire logic [CSPL_INT_SRC_W-1:0] int_src,
  output logic host_int_o,
  output logic host_int_oe
);
  // Register state
  logic [31:0] link_power_control_ff;
  logic [31:0] nxt_link_power_control;
  logic [31:0] config_load_bytes_ff;
  logic [31:0] nxt_config_load_bytes;
  logic [31:0] legacy_irq_select_ff;
  logic [31:0] nxt_legacy_irq_select;
  logic [CSPL_INT_SRC_W-1:0] int_status_ff;
  logic [CSPL_INT_SRC_W-1:0] nxt_int_status;
  logic sync_prev_ff;
  logic nxt_sync_prev;
  logic load_done_ff;
  logic nxt_load_done;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [CSPL_LEG_PINS-1:0] irq_level_ff;
  logic [CSPL_LEG_PINS-1:0] nxt_irq_level;

  // Decode and event terms
  logic [31:0] be_mask;
  logic wr_ok;
  logic hit_link_pwr;
  logic hit_cfg_load;
  logic hit_irq_sel;
  logic hit_int_stat;
  logic fsync;
  logic sync_fall;
  logic pri_rise;
  logic sec_rise;
  logic pri_gp_rise;
  logic sec_gp_rise;
  logic wake1_set;
  logic wake2_set;
  logic loader_en;
  logic [CSPL_LEG_PINS*CSPL_IS_MAP_W-1:0] irq_maps;

  // Edge detectors for wake and slot-12 general-purpose interrupts
  cspl_rise_det u_pri_wake (
    .clk(clk),
    .rst_n(rst_n),
    .din(primary_serial_in),
    .rise(pri_rise)
  );
  cspl_rise_det u_sec_wake (
    .clk(clk),
    .rst_n(rst_n),
    .din(secondary_codec_data),
    .rise(sec_rise)
  );
  cspl_rise_det u_pri_gp (
    .clk(clk),
    .rst_n(rst_n),
    .din(primary_gp_int),
    .rise(pri_gp_rise)
  );
  cspl_rise_det u_sec_gp (
    .clk(clk),
    .rst_n(rst_n),
    .din(secondary_gp_int),
    .rise(sec_gp_rise)
  );

  always_comb begin
    be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}},
               {8{cfg_be[0]}}};
    wr_ok = cfg_wr & config_write_protect;
    // Full-byte compare, so unmapped offsets hit nothing
    hit_link_pwr = cfg_addr == CSPL_OFS_LINK_PWR;
    hit_cfg_load = cfg_addr == CSPL_OFS_CFG_LOAD;
    hit_irq_sel = cfg_addr == CSPL_OFS_IRQ_SEL;
    hit_int_stat = cfg_addr == CSPL_OFS_INT_STAT;
    fsync = link_power_control_ff[CSPL_LP_FSYNC];
    sync_fall = sync_prev_ff & ~fsync;
    // Pin edges only count as wake while the link is down
    wake1_set = pri_rise & link_down;
    wake2_set = sec_rise & link_down;
  end

  // Register file next state
  always_comb begin
    nxt_link_power_control = link_power_control_ff;
    nxt_config_load_bytes = config_load_bytes_ff;
    nxt_legacy_irq_select = legacy_irq_select_ff;
    nxt_int_status = int_status_ff;
    nxt_sync_prev = fsync;
    nxt_load_done = 1'b1;
    nxt_rdata = rdata_ff;
    nxt_rvalid = cfg_rd;
    if (wr_ok && hit_link_pwr) begin
      nxt_link_power_control = (link_power_control_ff &
        ~(CSPL_LP_WR_MASK & be_mask)) |
        (cfg_wdata & CSPL_LP_WR_MASK & be_mask);
    end
    if (wr_ok && hit_irq_sel) begin
      nxt_legacy_irq_select = (legacy_irq_select_ff &
        ~(CSPL_IS_WR_MASK & be_mask)) |
        (cfg_wdata & CSPL_IS_WR_MASK & be_mask);
    end
    if (wr_ok && hit_cfg_load) begin
      nxt_config_load_bytes = (config_load_bytes_ff & ~be_mask) |
        (cfg_wdata & be_mask);
    end
    // EEPROM byte n lands in byte lane n
    if (ee_byte_valid) begin
      nxt_config_load_bytes[ee_byte_idx*8 +: 8] = ee_byte_data;
    end
    // Warm reset edge clears; a same-cycle wake wins
    if (sync_fall) begin
      nxt_link_power_control[CSPL_LP_WAKE1] = 1'b0;
      nxt_link_power_control[CSPL_LP_WAKE2] = 1'b0;
    end
    if (wake1_set) begin
      nxt_link_power_control[CSPL_LP_WAKE1] = 1'b1;
    end
    if (wake2_set) begin
      nxt_link_power_control[CSPL_LP_WAKE2] = 1'b1;
    end
    // Write one to clear; a new source pulse wins
    // Status clear stays outside the write protect
    if (cfg_wr && hit_int_stat) begin
      nxt_int_status = int_status_ff &
        ~(cfg_wdata[CSPL_INT_SRC_W-1:0] & be_mask[CSPL_INT_SRC_W-1:0]);
    end
    nxt_int_status = nxt_int_status | int_src;
    // Bus reset spares link power and irq select registers
    // Option bytes stay clear: only power-on restarts the loader
    if (!pci_rst_n) begin
      nxt_config_load_bytes = CSPL_CL_RESET;
      nxt_int_status = CSPL_INT_RESET;
    end
    if (cfg_rd) begin
      unique case (cfg_addr)
        CSPL_OFS_LINK_PWR: nxt_rdata = link_power_control_ff;
        CSPL_OFS_CFG_LOAD: nxt_rdata = config_load_bytes_ff;
        CSPL_OFS_IRQ_SEL: nxt_rdata = legacy_irq_select_ff;
        CSPL_OFS_INT_STAT: nxt_rdata = {{(32-CSPL_INT_SRC_W){1'b0}},
                                        int_status_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_power_control_ff <= CSPL_LP_RESET;
      config_load_bytes_ff <= CSPL_CL_RESET;
      legacy_irq_select_ff <= CSPL_IS_RESET;
      int_status_ff <= CSPL_INT_RESET;
      sync_prev_ff <= 1'b0;
      load_done_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rvalid_ff <= 1'b0;
    end else begin
      link_power_control_ff <= nxt_link_power_control;
      config_load_bytes_ff <= nxt_config_load_bytes;
      legacy_irq_select_ff <= nxt_legacy_irq_select;
      int_status_ff <= nxt_int_status;
      sync_prev_ff <= nxt_sync_prev;
      load_done_ff <= nxt_load_done;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Legacy interrupt pin drive
  always_comb begin
    nxt_irq_level = legacy_irq_req;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_level_ff <= '0;
    end else begin
      irq_level_ff <= nxt_irq_level;
    end
  end

  assign irq_maps = {
    legacy_irq_select_ff[CSPL_IS_MAP_C +: CSPL_IS_MAP_W],
    legacy_irq_select_ff[CSPL_IS_MAP_B +: CSPL_IS_MAP_W],
    legacy_irq_select_ff[CSPL_IS_MAP_A +: CSPL_IS_MAP_W]};

  // Maps reset to zero, so every pin powers up undriven
  for (genvar i = 0; i < CSPL_LEG_PINS; i++) begin : g_leg
    assign legacy_irq_oe[i] =
      (|irq_maps[i*CSPL_IS_MAP_W +: CSPL_IS_MAP_W])
      & legacy_irq_sw_en[i];
    assign legacy_irq_o[i] = irq_level_ff[i];
  end

  // Link pins are plain gates: they must act without a clock
  assign codec_reset_out_n =
    link_power_control_ff[CSPL_LP_RST_REL] & pci_rst_n;
  assign link_sync_pin = fsync | normal_sync;
  assign secondary_input_enable = link_power_control_ff[CSPL_LP_SEC_EN];
  assign secondary_codec_data =
    secondary_serial_in & secondary_input_enable;
  assign extended_gp_pin =
    secondary_serial_in & ~secondary_input_enable;
  assign pme_event =
    (pri_gp_rise & link_power_control_ff[CSPL_LP_PRI_EV]) |
    (sec_gp_rise & link_power_control_ff[CSPL_LP_SEC_EV]);

  // One load attempt per power-on reset release
  // Disable bit both blocks the start and detaches the pins
  assign loader_en = ~link_power_control_ff[CSPL_LP_EE_DIS];
  assign eeprom_load_start = ~load_done_ff & loader_en;
  assign eeprom_pins_attach = loader_en;

  assign cold_d3_support = legacy_irq_select_ff[CSPL_IS_AUX_SUPPLY_SUPPORT];
  assign aux_current_code = legacy_irq_select_ff[CSPL_IS_VAC +: 3];
  assign aux_power_flag = legacy_irq_select_ff[CSPL_IS_AUX_POWER_FLAG];
  assign firmware_flags = legacy_irq_select_ff[CSPL_IS_FWF +: 3];
  assign io_trap_fire =
    io_trap_hit & ~legacy_irq_select_ff[CSPL_IS_GTD];

  // Open-drain host line: pulled low while any source pends
  assign host_int_o = 1'b0;
  assign host_int_oe = |int_status_ff;

  assign cfg_rdata = rdata_ff;
  assign cfg_rvalid = rvalid_ff;
endmodule
`default_nettype wire

// ==== tb/cspl_regs_props.sv ====
/* Port checker for cspl_regs; assumes one clock and rst_n as reset. */
`default_nettype none
module cspl_regs_props
  import cspl_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pci_rst_n,
  // Codec link
  input wire logic codec_reset_out_n,
  input wire logic secondary_serial_in,
  input wire logic secondary_input_enable,
  input wire logic secondary_codec_data,
  input wire logic extended_gp_pin,
  input wire logic primary_gp_int,
  input wire logic secondary_gp_int,
  input wire logic pme_event,
  // Loader, trapping, host interrupt
  input wire logic eeprom_load_start,
  input wire logic eeprom_pins_attach,
  input wire logic io_trap_hit,
  input wire logic io_trap_fire,
  input wire logic [CSPL_INT_SRC_W-1:0] int_src,
  input wire logic host_int_o,
  input wire logic host_int_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_CRST: assert property (!pci_rst_n |-> !codec_reset_out_n)
    else $error("codec reset released during bus reset");
  AST_SEC_ON: assert property (secondary_input_enable |->
    secondary_codec_data == secondary_serial_in && !extended_gp_pin)
    else $error("secondary pin not routed to codec input");
  AST_SEC_OFF: assert property (!secondary_input_enable |->
    extended_gp_pin == secondary_serial_in && !secondary_codec_data)
    else $error("secondary pin not routed to gp pin");
  AST_PME: assert property (pme_event |->
    $rose(primary_gp_int) || $rose(secondary_gp_int))
    else $error("event without a gp interrupt rise");
  AST_EE: assert property (eeprom_load_start |-> eeprom_pins_attach)
    else $error("load started with pins detached");
  AST_TRAP: assert property (io_trap_fire |-> io_trap_hit)
    else $error("trap fired without a hit");
  AST_HSET: assert property (int_src != '0 |=> host_int_oe)
    else $error("source did not reach host line");
  AST_HDRV: assert property (!host_int_o)
    else $error("host line driven high");
  cover property (pme_event);
  cover property (host_int_oe);
  cover property (io_trap_fire);
endmodule
bind cspl_regs cspl_regs_props cspl_regs_props_i (.clk, .rst_n, .pci_rst_n,
  .codec_reset_out_n, .secondary_serial_in, .secondary_input_enable,
  .secondary_codec_data, .extended_gp_pin, .primary_gp_int,
  .secondary_gp_int, .pme_event, .eeprom_load_start, .eeprom_pins_attach,
  .io_trap_hit, .io_trap_fire, .int_src, .host_int_o, .host_int_oe);
`default_nettype wire

// ==== tb/cspl_codec_model.sv ====
/* Codec pair and EEPROM model; assumes the bench sets line edges via req. */
`default_nettype none
module cspl_codec_model #(
  parameter logic [31:0] EE_BYTES = 32'h0000_0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests
  input wire logic eeprom_load_start,
  input wire logic [3:0] req,
  // Codec and EEPROM lines
  output logic primary_serial_in,
  output logic secondary_serial_in,
  output logic primary_gp_int,
  output logic secondary_gp_int,
  output logic ee_byte_valid,
  output logic [1:0] ee_byte_idx,
  output logic [7:0] ee_byte_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  // Idle byte lines invert, so a stale byte never looks valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {primary_serial_in, secondary_serial_in, ee_byte_valid} <= 3'h0;
      {primary_gp_int, secondary_gp_int, ee_byte_idx} <= 4'h0;
      ee_byte_data <= 8'h00;
      n <= 0;
    end else begin
      {secondary_gp_int, primary_gp_int} <= req[3:2];
      {secondary_serial_in, primary_serial_in} <= req[1:0];
      n <= eeprom_load_start ? 4 : (n > 0 ? n - 1 : 0);
      ee_byte_valid <= n > 0;
      ee_byte_idx <= 2'(4 - n);
      ee_byte_data <= n > 0 ? EE_BYTES[8 * (4 - n) +: 8] : ~ee_byte_data;
    end
  end
endmodule
`default_nettype wire

// ==== tb/cspl_regs_test.sv ====
/* Self-checking bench for cspl_regs; assumes a 4 ns clock. */
`default_nettype none
module cspl_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cspl_pkg::*;
  localparam logic [31:0] EEV = 32'h5a3c_c3a5;
  localparam logic [31:0] B = 32'h0000_0101;
  logic clk = 1'b0;
  logic rst_n, pci_rst_n, cfg_wr, cfg_rd, config_write_protect, link_down;
  logic io_trap_hit, primary_serial_in, secondary_serial_in, ee_byte_valid;
  logic primary_gp_int, secondary_gp_int, cfg_rvalid, codec_reset_out_n;
  logic link_sync_pin, secondary_input_enable, pme_event, eeprom_load_start;
  logic eeprom_pins_attach, cold_d3_support, aux_power_flag, io_trap_fire;
  logic host_int_o, host_int_oe, normal_sync;
  logic [1:0] ee_byte_idx;
  logic [2:0] legacy_irq_sw_en, legacy_irq_oe, aux_current_code;
  logic [2:0] firmware_flags, legacy_irq_req, legacy_irq_o;
  logic [3:0] req;
  logic [7:0] cfg_addr, ee_byte_data, int_src, s;
  logic [31:0] cfg_wdata, cfg_rdata, v;
  logic [31:0] q[$];
  int seed = 29119;
  int checks = 0;
  int miscompares = 0;
  always #2 clk = ~clk;
  cspl_regs cspl_regs_i (.clk, .rst_n, .pci_rst_n, .cfg_wr, .cfg_rd,
    .cfg_addr, .cfg_be(4'hf), .cfg_wdata, .config_write_protect, .cfg_rdata,
    .cfg_rvalid, .link_down, .normal_sync, .primary_serial_in,
    .secondary_serial_in, .primary_gp_int, .secondary_gp_int,
    .codec_reset_out_n, .link_sync_pin, .secondary_codec_data(),
    .extended_gp_pin(), .secondary_input_enable, .pme_event, .ee_byte_valid,
    .ee_byte_idx, .ee_byte_data, .eeprom_load_start, .eeprom_pins_attach,
    .cold_d3_support, .aux_current_code, .aux_power_flag, .firmware_flags,
    .io_trap_hit, .io_trap_fire, .legacy_irq_sw_en, .legacy_irq_req,
    .legacy_irq_o, .legacy_irq_oe, .int_src, .host_int_o, .host_int_oe);
  cspl_codec_model #(.EE_BYTES(EEV)) cspl_codec_model_i (.clk, .rst_n,
    .eeprom_load_start, .req, .primary_serial_in, .secondary_serial_in,
    .primary_gp_int, .secondary_gp_int, .ee_byte_valid, .ee_byte_idx,
    .ee_byte_data);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Read notes its expectation; the monitor below compares
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} <= {w, !w, a, d};
    if (!w) q.push_back(d);
    @(posedge clk);
    {cfg_wr, cfg_rd} <= 2'b00;
  endtask
  always @(posedge clk) begin
    if (cfg_rvalid === 1'b1) chk(cfg_rdata, q.pop_front());
  end
  initial begin
    {rst_n, cfg_wr, cfg_rd, config_write_protect, link_down} <= 5'h00;
    {io_trap_hit, req, legacy_irq_sw_en, int_src} <= 16'h0000;
    {pci_rst_n, cfg_addr, cfg_wdata} <= {1'b1, 40'h0};
    {normal_sync, legacy_irq_req} <= 4'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk(codec_reset_out_n, 0);
    acc(0, CSPL_OFS_CFG_LOAD, EEV);
    acc(1, CSPL_OFS_LINK_PWR, B);
    acc(0, CSPL_OFS_LINK_PWR, CSPL_LP_RESET);
    acc(0, 8'h40, 32'h0);
    config_write_protect <= 1'b1;
    acc(1, CSPL_OFS_LINK_PWR, '1);
    @(negedge clk);
    chk({codec_reset_out_n, link_sync_pin}, 2'b11);
    chk({eeprom_pins_attach, secondary_input_enable}, 2'b01);
    acc(0, CSPL_OFS_LINK_PWR, CSPL_LP_WR_MASK);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      if (i == 0) v = v & 32'hfff0_f0f0;
      legacy_irq_sw_en <= v[6:4];
      legacy_irq_req <= v[9:7];
      io_trap_hit <= v[22];
      acc(1, CSPL_OFS_IRQ_SEL, v);
      @(negedge clk);
      chk({cold_d3_support, aux_current_code}, v[31:28]);
      chk({aux_power_flag, firmware_flags}, v[27:24]);
      chk(io_trap_fire, v[22] & !v[23]);
      chk(legacy_irq_oe, {|v[19:16], |v[11:8], |v[3:0]} & v[6:4]);
      chk(legacy_irq_o, v[9:7]);
      @(posedge clk);
    end
    pci_rst_n <= 1'b0;
    @(negedge clk);
    chk(codec_reset_out_n, 0);
    @(posedge clk);
    pci_rst_n <= 1'b1;
    acc(0, CSPL_OFS_IRQ_SEL, v & CSPL_IS_WR_MASK);
    acc(0, CSPL_OFS_LINK_PWR, CSPL_LP_WR_MASK);
    link_down <= 1'b1;
    acc(1, CSPL_OFS_LINK_PWR, B);
    req <= 4'h3;
    repeat (3) @(posedge clk);
    acc(0, CSPL_OFS_LINK_PWR, B | 32'hc);
    acc(1, CSPL_OFS_LINK_PWR, B | 32'h2);
    acc(1, CSPL_OFS_LINK_PWR, B);
    acc(0, CSPL_OFS_LINK_PWR, B);
    @(negedge clk);
    chk(link_sync_pin, 0);
    @(posedge clk);
    normal_sync <= 1'b1;
    @(negedge clk);
    chk(link_sync_pin, 1);
    @(posedge clk);
    normal_sync <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      acc(1, CSPL_OFS_LINK_PWR, e ? B | 32'hc000 : B);
      for (int j = 2; j < 4; j++) begin
        req <= 4'h3 | 4'(1 << j);
        @(posedge clk);
        @(negedge clk);
        chk(pme_event, e);
        @(posedge clk);
        req <= 4'h3;
        @(posedge clk);
      end
    end
    s = 8'($random(seed)) | 8'h01;
    int_src <= s;
    @(posedge clk);
    int_src <= 8'h00;
    acc(0, CSPL_OFS_INT_STAT, {24'h0, s});
    acc(1, CSPL_OFS_INT_STAT, 32'h0000_00ff);
    @(negedge clk);
    chk(host_int_oe, 0);
    repeat (4) @(posedge clk);
    give_verdict;
  end
  // Run needs about 85 cycles; far longer means a hang
  initial begin
    #20000;
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
